// ===== bench/cbwd_card_model.sv
// card side transfer sequencer, marks frame start and transfer end
`timescale 1ns/10ps
module cbwd_card_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // request from the bench, last phase request from the bridge
  input wire logic go_i,
  input wire logic [7:0] len_i,
  input wire logic last_phase_i,
  // transfer events
  output logic frame_start_o,
  output logic txn_end_o
);
  logic busy_reg;
  logic [7:0] cnt_reg;

  // runs len_i + 1 data phases, or stops at the end of the phase in which the bridge asks to finish
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
      frame_start_o <= 1'b0;
      txn_end_o <= 1'b0;
    end else begin
      frame_start_o <= go_i && !busy_reg;
      txn_end_o <= 1'b0;
      if (go_i && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg <= 8'h00;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == len_i || last_phase_i) begin
          busy_reg <= 1'b0;
          txn_end_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== bench/cbwd_window_decode_assertions.sv
// concurrent checks on the ports of the window decode block
`timescale 1ns/10ps
module cbwd_window_decode_checker
  import cbwd_pkg::*;
#(
  parameter int NSOCK = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // configuration access
  input wire logic cfg_rd_i,
  input wire logic [CBWD_ADDR_W-1:0] cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  // host side decode
  input wire logic [CBWD_ADDR_W-1:0] pci_addr_i,
  input wire logic pci_mem_i,
  input wire logic pci_io_i,
  input wire logic pci_cfg_i,
  input wire logic pci_cfg_type1_i,
  input wire logic [NSOCK-1:0] pci_mem_hit_o,
  input wire logic [NSOCK-1:0] pci_mem_pref_o,
  input wire logic [NSOCK-1:0] pci_io_hit_o,
  input wire logic [NSOCK-1:0] cfg_fwd_o,
  input wire logic [NSOCK-1:0] cfg_fwd_type0_o,
  // card side
  input wire logic [NSOCK-1:0] cb_mem_i,
  input wire logic [NSOCK-1:0] cb_io_i,
  input wire logic [NSOCK-1:0] cb_to_pci_o,
  input wire logic [NSOCK-1:0] cb_txn_end_i,
  input wire logic [NSOCK-1:0] lat_expired_o,
  input wire logic [NSOCK-1:0] cb_last_phase_o
);
  default clocking cb_clk @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // read answer comes exactly one cycle later, data holds between reads
  rd_answer_a: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered");
  rd_quiet_a: assert property (!cfg_rd_i |=> !cfg_rvalid_o)
    else $error("stray read valid");
  rdata_hold_a: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
    else $error("rdata moved");
  // decode results need their qualifier one cycle earlier
  mem_qual_a: assert property (!pci_mem_i |=> pci_mem_hit_o == '0)
    else $error("mem hit unasked");
  pref_hit_a: assert property ((pci_mem_pref_o & ~pci_mem_hit_o) == '0)
    else $error("pref no hit");
  io_page_a: assert property (
    pci_io_i && pci_addr_i[31:16] != 16'h0000 |=> pci_io_hit_o == '0)
    else $error("io hit off page");
  fwd_type1_a: assert property (!(pci_cfg_i && pci_cfg_type1_i) |=> cfg_fwd_o == '0)
    else $error("config forwarded wrongly");
  type0_fwd_a: assert property ((cfg_fwd_type0_o & ~cfg_fwd_o) == '0)
    else $error("type0 no fwd");
  card_qual_a: assert property (!(cb_mem_i[0] || cb_io_i[0]) |=> !cb_to_pci_o[0])
    else $error("card fwd unasked");
  // expiry ends the transfer after the current data phase
  last_phase_a: assert property (cb_last_phase_o == (lat_expired_o & ~cb_txn_end_i))
    else $error("last phase wrong");
  exp_hold_a: assert property (lat_expired_o[0] && !cb_txn_end_i[0] |=> lat_expired_o[0])
    else $error("expiry dropped");
  exp_clear_a: assert property (cb_txn_end_i[0] |=> !lat_expired_o[0])
    else $error("expiry stuck");
endmodule

bind cbwd_window_decode cbwd_window_decode_checker #(.NSOCK(NSOCK)) chk_u (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
  .pci_addr_i(pci_addr_i), .pci_mem_i(pci_mem_i), .pci_io_i(pci_io_i), .pci_cfg_i(pci_cfg_i),
  .pci_cfg_type1_i(pci_cfg_type1_i), .pci_mem_hit_o(pci_mem_hit_o),
  .pci_mem_pref_o(pci_mem_pref_o), .pci_io_hit_o(pci_io_hit_o), .cfg_fwd_o(cfg_fwd_o),
  .cfg_fwd_type0_o(cfg_fwd_type0_o), .cb_mem_i(cb_mem_i), .cb_io_i(cb_io_i),
  .cb_to_pci_o(cb_to_pci_o), .cb_txn_end_i(cb_txn_end_i), .lat_expired_o(lat_expired_o),
  .cb_last_phase_o(cb_last_phase_o));

// ===== bench/cbwd_window_decode_bench.sv
// self-checking bench for the window decode block
`timescale 1ns/10ps
module cbwd_window_decode_bench;
  import cbwd_pkg::*;
  logic clk, rst_n, f, wr, rd, rv, mem, io, cfg, t1, go, fs, te;
  logic [7:0] a, bus, len;
  logic [3:0] be, pref;
  logic [31:0] wd, rdat, pa;
  logic [63:0] cba;
  logic [1:0] cbm, cbi, mh, mp, ih, fw, f0, c2p, lx, lp;
  int fails, n_tests, cyc, n;

  cbwd_window_decode dut_u (.clock_i(clk), .rst_n_i(rst_n), .cfg_func_i(f), .cfg_addr_i(a),
    .cfg_be_i(be), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_wdata_i(wd), .cfg_rdata_o(rdat),
    .cfg_rvalid_o(rv), .pci_addr_i(pa), .pci_mem_i(mem), .pci_io_i(io), .pci_cfg_i(cfg),
    .pci_cfg_type1_i(t1), .pci_cfg_bus_i(bus), .pci_mem_hit_o(mh), .pci_mem_pref_o(mp),
    .pci_io_hit_o(ih), .cfg_fwd_o(fw), .cfg_fwd_type0_o(f0), .mem_pref_ctl_i(pref),
    .cb_addr_i(cba), .cb_mem_i(cbm), .cb_io_i(cbi), .cb_to_pci_o(c2p),
    .cb_frame_start_i({1'b0, fs}), .cb_txn_end_i({1'b0, te}), .lat_expired_o(lx),
    .cb_last_phase_o(lp));
  cbwd_card_model card_u (.clock_i(clk), .rst_n_i(rst_n), .go_i(go), .len_i(len),
    .last_phase_i(lp[0]), .frame_start_o(fs), .txn_end_o(te));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cwr(input logic fn, input logic [7:0] ad, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk); #1 f = fn; a = ad; be = b; wd = d; wr = 1'b1;
    @(posedge clk); #1 wr = 1'b0;
  endtask
  task automatic crd(input logic fn, input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clk); #1 f = fn; a = ad; rd = 1'b1;
    @(posedge clk); #1 rd = 1'b0;
    chk("rvalid", {31'h0, rv}, 32'h1);
    chk("rdata", rdat, exp);
  endtask
  // q = {type1, cfg, io, mem}; e1 is the hit or forward, e2 the prefetch or type0 result
  task automatic dec(input logic [3:0] q, input logic [31:0] ad, input logic [1:0] e1, e2);
    @(posedge clk); #1 {t1, cfg, io, mem} = q; pa = ad; bus = ad[7:0];
    @(posedge clk); #1 {t1, cfg, io, mem} = 4'h0;
    if (q[0]) chk("mem hit", {30'h0, mh}, {30'h0, e1});
    if (q[0]) chk("mem pref", {30'h0, mp}, {30'h0, e2});
    if (q[1]) chk("io hit", {30'h0, ih}, {30'h0, e1});
    if (q[2]) chk("cfg fwd", {30'h0, fw}, {30'h0, e1});
    if (q[2]) chk("cfg type0", {30'h0, f0}, {30'h0, e2});
  endtask
  task automatic card(input logic m, input logic [31:0] ad, input logic e);
    @(posedge clk); #1 cbm = {1'b0, m}; cbi = {1'b0, !m}; cba = {32'h0, ad};
    @(posedge clk); #1 cbm = 2'b00; cbi = 2'b00;
    chk("card to host", {31'h0, c2p[0]}, {31'h0, e});
  endtask
  // cycles from the frame start edge until expiry is seen, 60 when it never comes
  task automatic lat(input logic [7:0] l, input logic [7:0] ln, input int exp);
    cwr(1'b0, 8'h18, 4'h8, {l, 24'h0});
    @(posedge clk); #1 len = ln; go = 1'b1;
    @(posedge clk); #1 go = 1'b0;
    @(posedge clk); #1 n = 0;
    while (!lx[0] && n < 60) begin
      @(posedge clk); #1 n++;
    end
    chk("expiry cycles", n, exp);
    if (exp < 60) chk("last phase", {31'h0, lp[0]}, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk("expiry cleared", {30'h0, lx}, 32'h0);
  endtask
  task automatic complete_run;
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, the full sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    {f, wr, rd, mem, io, cfg, t1, go, a, bus, len, be, wd, pa, cba, cbm, cbi} = '0;
    pref = 4'b0001;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 9; i++) crd(1'b0, 8'h18 + 8'(4 * i), 32'h0);
    dec(4'h1, 32'h00000000, 2'b00, 2'b00);
    dec(4'h2, 32'h00000000, 2'b00, 2'b00);
    cwr(1'b0, 8'h18, 4'hF, 32'h03050201);
    crd(1'b0, 8'h18, 32'h03050201);
    crd(1'b1, 8'h18, 32'h0);
    cwr(1'b1, 8'h18, 4'h4, 32'hFFFFFFFF);
    crd(1'b1, 8'h18, 32'h00FF0000);
    crd(1'b0, 8'h18, 32'h03050201);
    dec(4'hC, 32'h02, 2'b11, 2'b01);
    dec(4'hC, 32'h05, 2'b11, 2'b00);
    dec(4'hC, 32'h06, 2'b10, 2'b00);
    dec(4'hC, 32'h00, 2'b00, 2'b00);
    dec(4'h4, 32'h02, 2'b00, 2'b00);
    cwr(1'b0, 8'h1C, 4'hF, 32'hFFFFFFFF);
    crd(1'b0, 8'h1C, 32'hFFFFF000);
    cwr(1'b0, 8'h1C, 4'hF, 32'h10000ABC);
    cwr(1'b0, 8'h20, 4'hF, 32'h10002FFF);
    crd(1'b0, 8'h1C, 32'h10000000);
    crd(1'b0, 8'h20, 32'h10002000);
    cwr(1'b0, 8'h24, 4'hF, 32'h30000000);
    cwr(1'b0, 8'h28, 4'hF, 32'h30000000);
    dec(4'h1, 32'h0FFFFFFC, 2'b00, 2'b00);
    dec(4'h1, 32'h10000000, 2'b01, 2'b01);
    dec(4'h1, 32'h10002FFC, 2'b01, 2'b01);
    dec(4'h1, 32'h10003000, 2'b00, 2'b00);
    dec(4'h1, 32'h30000FFF, 2'b01, 2'b00);
    pref = 4'b0010;
    dec(4'h1, 32'h30000000, 2'b01, 2'b01);
    cwr(1'b0, 8'h2C, 4'hF, 32'hFFFFFFFF);
    crd(1'b0, 8'h2C, 32'h0000FFFC);
    cwr(1'b0, 8'h2C, 4'hF, 32'h00001001);
    cwr(1'b0, 8'h30, 4'hF, 32'hFFFF1FF3);
    crd(1'b0, 8'h30, 32'h00001FF0);
    dec(4'h2, 32'h00001FF3, 2'b01, 2'b00);
    dec(4'h2, 32'h00001FF4, 2'b00, 2'b00);
    dec(4'h2, 32'h00000FFF, 2'b00, 2'b00);
    dec(4'h2, 32'h00001000, 2'b01, 2'b00);
    dec(4'h2, 32'h00011000, 2'b00, 2'b00);
    card(1'b1, 32'h10001000, 1'b0);
    card(1'b1, 32'h40000000, 1'b1);
    card(1'b0, 32'h00001500, 1'b0);
    card(1'b0, 32'h00002000, 1'b1);
    lat(8'h00, 8'd50, 1);
    lat(8'h03, 8'd50, 4);
    lat(8'h20, 8'd4, 60);
    complete_run();
  end
endmodule

// ===== hw/cbwd_lat_timer.sv
// cardbus initiator latency timer for one socket
`timescale 1ns/10ps
module cbwd_lat_timer
  import cbwd_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // link cycle enable and programmed limit
  input wire logic cclk_en_i,
  input wire logic [CBWD_BUS_W-1:0] limit_i,
  // initiator transaction events
  input wire logic frame_start_i,
  input wire logic txn_end_i,
  // timer results
  output logic expired_o,
  output logic last_phase_o
);
  cbwd_lat_e state_reg, state_next;
  logic [CBWD_BUS_W-1:0] cnt_reg, cnt_next;
  wire cnt_done = cnt_reg >= limit_i;
  wire cnt_step = cclk_en_i & ~cnt_done;

  // end of transaction wins over a new start in the same cycle
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      CBWD_LAT_IDLE: begin
        if (frame_start_i && !txn_end_i) begin
          state_next = CBWD_LAT_COUNT;
          cnt_next = CBWD_LAT_RST;
        end
      end
      CBWD_LAT_COUNT: begin
        if (txn_end_i) begin
          state_next = CBWD_LAT_IDLE;
        end else if (cnt_done) begin
          state_next = CBWD_LAT_EXPIRED;
        end else if (cnt_step) begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      CBWD_LAT_EXPIRED: begin
        if (txn_end_i) begin
          state_next = CBWD_LAT_IDLE;
        end
      end
      default: begin
        state_next = CBWD_LAT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= CBWD_LAT_IDLE;
      cnt_reg <= CBWD_LAT_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // the initiator ends at the close of the data phase under way
  assign expired_o = (state_reg == CBWD_LAT_EXPIRED);
  assign last_phase_o = expired_o & ~txn_end_i;
endmodule

// ===== hw/cbwd_window_decode.sv
// per-socket bus number, latency and address window decode of the bridge
`timescale 1ns/10ps
module cbwd_window_decode
  import cbwd_pkg::*;
#(
  parameter int NSOCK = 2,
  parameter int CCLK_DIV = 1,
  localparam int FW = (NSOCK > 1) ? $clog2(NSOCK) : 1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // configuration access, one function per socket
  input wire logic [FW-1:0] cfg_func_i,
  input wire logic [CBWD_OFS_W-1:0] cfg_addr_i,
  input wire logic [CBWD_BE_W-1:0] cfg_be_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [CBWD_ADDR_W-1:0] cfg_wdata_i,
  output logic [CBWD_ADDR_W-1:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // host side transaction to decode
  input wire logic [CBWD_ADDR_W-1:0] pci_addr_i,
  input wire logic pci_mem_i,
  input wire logic pci_io_i,
  input wire logic pci_cfg_i,
  input wire logic pci_cfg_type1_i,
  input wire logic [CBWD_BUS_W-1:0] pci_cfg_bus_i,
  // host side decode results
  output logic [NSOCK-1:0] pci_mem_hit_o,
  output logic [NSOCK-1:0] pci_mem_pref_o,
  output logic [NSOCK-1:0] pci_io_hit_o,
  output logic [NSOCK-1:0] cfg_fwd_o,
  output logic [NSOCK-1:0] cfg_fwd_type0_o,
  // prefetch control, bridge control bits 8 and 9 per socket
  input wire logic [CBWD_PREF_BITS*NSOCK-1:0] mem_pref_ctl_i,
  // card side cycles to decode
  input wire logic [CBWD_ADDR_W*NSOCK-1:0] cb_addr_i,
  input wire logic [NSOCK-1:0] cb_mem_i,
  input wire logic [NSOCK-1:0] cb_io_i,
  output logic [NSOCK-1:0] cb_to_pci_o,
  // card side initiator latency
  input wire logic [NSOCK-1:0] cb_frame_start_i,
  input wire logic [NSOCK-1:0] cb_txn_end_i,
  output logic [NSOCK-1:0] lat_expired_o,
  output logic [NSOCK-1:0] cb_last_phase_o
);
  localparam logic [FW:0] NS_W = (FW + 1)'(NSOCK);
  localparam logic [7:0] DIV_LAST = 8'(CCLK_DIV - 1);

  // address inside [bottom, top], window off while both are zero
  function automatic logic win_hit(input cbwd_cmp_t a, input cbwd_cmp_t lo,
                                   input cbwd_cmp_t hi);
    win_hit = (a >= lo) && (a <= hi) && ((lo | hi) != '0);
  endfunction

  // byte enable merge of a write into the current word
  function automatic logic [CBWD_ADDR_W-1:0] be_merge(input logic [CBWD_ADDR_W-1:0] cur,
                                                       input logic [CBWD_ADDR_W-1:0] wd,
                                                       input logic [CBWD_BE_W-1:0] be);
    logic [CBWD_ADDR_W-1:0] m;
    m = cur;
    for (int i = 0; i < CBWD_BE_W; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    be_merge = m;
  endfunction

  // link clock enable; one pulse per CCLK_DIV host clocks
  logic [7:0] div_reg;
  wire cclk_en = (div_reg == DIV_LAST);
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= cclk_en ? 8'h00 : div_reg + 8'h01;
    end
  end

  // one word view per socket for the read path
  logic [CBWD_ADDR_W-1:0] cur_w [NSOCK];
  wire func_ok = {1'b0, cfg_func_i} < NS_W;
  wire [CBWD_ADDR_W-1:0] rd_word = func_ok ? cur_w[cfg_func_i] : CBWD_WORD_ZERO;

  // read data registered, answer one clock after the request
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o <= CBWD_WORD_ZERO;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        cfg_rdata_o <= rd_word;
      end
    end
  end

  for (genvar s = 0; s < NSOCK; s++) begin : g_sock
    // separate storage per function, never shared between sockets
    logic [CBWD_BUS_W-1:0] pbus_reg, cbus_reg, sub_reg, lat_reg;
    logic [CBWD_MEM_FW-1:0] mb0_reg, mt0_reg, mb1_reg, mt1_reg;
    logic [CBWD_IO_FW-1:0] ib0_reg, it0_reg, ib1_reg, it1_reg;
    logic mhit_reg, mpref_reg, iohit_reg, cfwd_reg, ct0_reg, cbfwd_reg;

    wire wr = cfg_wr_i & (cfg_func_i == FW'(s));
    wire [CBWD_ADDR_W-1:0] w_bus = {lat_reg, sub_reg, cbus_reg, pbus_reg};
    wire [CBWD_ADDR_W-1:0] w_mb0 = {mb0_reg, CBWD_MEM_LOW_ZERO};
    wire [CBWD_ADDR_W-1:0] w_mt0 = {mt0_reg, CBWD_MEM_LOW_ZERO};
    wire [CBWD_ADDR_W-1:0] w_mb1 = {mb1_reg, CBWD_MEM_LOW_ZERO};
    wire [CBWD_ADDR_W-1:0] w_mt1 = {mt1_reg, CBWD_MEM_LOW_ZERO};
    wire [CBWD_ADDR_W-1:0] w_ib0 = {CBWD_IO_PAGE, ib0_reg, CBWD_IO_LOW_ZERO};
    wire [CBWD_ADDR_W-1:0] w_it0 = {CBWD_IO_PAGE, it0_reg, CBWD_IO_LOW_ZERO};
    wire [CBWD_ADDR_W-1:0] w_ib1 = {CBWD_IO_PAGE, ib1_reg, CBWD_IO_LOW_ZERO};
    wire [CBWD_ADDR_W-1:0] w_it1 = {CBWD_IO_PAGE, it1_reg, CBWD_IO_LOW_ZERO};

    // register select; unmapped offsets read zero and drop writes
    assign cur_w[s] = (cfg_addr_i == CBWD_OFS_BUSNUM) ? w_bus :
                      (cfg_addr_i == CBWD_OFS_MEM0_BOT) ? w_mb0 :
                      (cfg_addr_i == CBWD_OFS_MEM0_TOP) ? w_mt0 :
                      (cfg_addr_i == CBWD_OFS_MEM1_BOT) ? w_mb1 :
                      (cfg_addr_i == CBWD_OFS_MEM1_TOP) ? w_mt1 :
                      (cfg_addr_i == CBWD_OFS_IO0_BOT) ? w_ib0 :
                      (cfg_addr_i == CBWD_OFS_IO0_TOP) ? w_it0 :
                      (cfg_addr_i == CBWD_OFS_IO1_BOT) ? w_ib1 :
                      (cfg_addr_i == CBWD_OFS_IO1_TOP) ? w_it1 : CBWD_WORD_ZERO;
    wire [CBWD_ADDR_W-1:0] m = be_merge(cur_w[s], cfg_wdata_i, cfg_be_i);
    wire [CBWD_MEM_FW-1:0] m_mem = m[CBWD_ADDR_W-1:CBWD_MEM_LSB];
    wire [CBWD_IO_FW-1:0] m_io = m[CBWD_IO_MSB:CBWD_IO_LSB];
    wire bus_wr = wr && (cfg_addr_i == CBWD_OFS_BUSNUM);

    // register writes; fixed bits are simply not stored
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pbus_reg <= CBWD_BUS_RST;
        cbus_reg <= CBWD_BUS_RST;
        sub_reg <= CBWD_BUS_RST;
        lat_reg <= CBWD_LAT_RST;
        mb0_reg <= CBWD_MEM_RST;
        mt0_reg <= CBWD_MEM_RST;
        mb1_reg <= CBWD_MEM_RST;
        mt1_reg <= CBWD_MEM_RST;
        ib0_reg <= CBWD_IO_RST;
        it0_reg <= CBWD_IO_RST;
        ib1_reg <= CBWD_IO_RST;
        it1_reg <= CBWD_IO_RST;
      end else begin
        if (bus_wr) begin
          pbus_reg <= m[CBWD_OFS_PBUS[1:0]*8 +: CBWD_BUS_W];
          cbus_reg <= m[CBWD_OFS_CBUS[1:0]*8 +: CBWD_BUS_W];
          sub_reg <= m[CBWD_OFS_SUB[1:0]*8 +: CBWD_BUS_W];
          lat_reg <= m[CBWD_OFS_LAT[1:0]*8 +: CBWD_BUS_W];
        end
        if (wr && cfg_addr_i == CBWD_OFS_MEM0_BOT) mb0_reg <= m_mem;
        if (wr && cfg_addr_i == CBWD_OFS_MEM0_TOP) mt0_reg <= m_mem;
        if (wr && cfg_addr_i == CBWD_OFS_MEM1_BOT) mb1_reg <= m_mem;
        if (wr && cfg_addr_i == CBWD_OFS_MEM1_TOP) mt1_reg <= m_mem;
        if (wr && cfg_addr_i == CBWD_OFS_IO0_BOT) ib0_reg <= m_io;
        if (wr && cfg_addr_i == CBWD_OFS_IO0_TOP) it0_reg <= m_io;
        if (wr && cfg_addr_i == CBWD_OFS_IO1_BOT) ib1_reg <= m_io;
        if (wr && cfg_addr_i == CBWD_OFS_IO1_TOP) it1_reg <= m_io;
      end
    end

    // page-granular compare covers the whole top page
    wire [CBWD_ADDR_W-1:0] cb_a = cb_addr_i[s*CBWD_ADDR_W +: CBWD_ADDR_W];
    wire [CBWD_MEM_FW-1:0] pa_pg = pci_addr_i[CBWD_ADDR_W-1:CBWD_MEM_LSB];
    wire [CBWD_MEM_FW-1:0] ca_pg = cb_a[CBWD_ADDR_W-1:CBWD_MEM_LSB];
    wire ph0 = win_hit(cbwd_cmp_t'(pa_pg), cbwd_cmp_t'(mb0_reg), cbwd_cmp_t'(mt0_reg));
    wire ph1 = win_hit(cbwd_cmp_t'(pa_pg), cbwd_cmp_t'(mb1_reg), cbwd_cmp_t'(mt1_reg));
    wire ch0 = win_hit(cbwd_cmp_t'(ca_pg), cbwd_cmp_t'(mb0_reg), cbwd_cmp_t'(mt0_reg));
    wire ch1 = win_hit(cbwd_cmp_t'(ca_pg), cbwd_cmp_t'(mb1_reg), cbwd_cmp_t'(mt1_reg));
    wire [CBWD_PREF_BITS-1:0] pref = mem_pref_ctl_i[s*CBWD_PREF_BITS +: CBWD_PREF_BITS];

    // i/o compare drops the low two bits, so the top covers addresses up to ...11 though it reads as ...00
    wire [CBWD_IO_FW-1:0] pa_io = pci_addr_i[CBWD_IO_MSB:CBWD_IO_LSB];
    wire [CBWD_IO_FW-1:0] ca_io = cb_a[CBWD_IO_MSB:CBWD_IO_LSB];
    wire p_pg0 = pci_addr_i[CBWD_ADDR_W-1:CBWD_IO_PAGE_LSB] == CBWD_IO_PAGE;
    wire c_pg0 = cb_a[CBWD_ADDR_W-1:CBWD_IO_PAGE_LSB] == CBWD_IO_PAGE;
    wire pio = p_pg0 & (win_hit(cbwd_cmp_t'(pa_io), cbwd_cmp_t'(ib0_reg), cbwd_cmp_t'(it0_reg))
                      | win_hit(cbwd_cmp_t'(pa_io), cbwd_cmp_t'(ib1_reg), cbwd_cmp_t'(it1_reg)));
    wire cio = c_pg0 & (win_hit(cbwd_cmp_t'(ca_io), cbwd_cmp_t'(ib0_reg), cbwd_cmp_t'(it0_reg))
                      | win_hit(cbwd_cmp_t'(ca_io), cbwd_cmp_t'(ib1_reg), cbwd_cmp_t'(it1_reg)));

    // type 1 config on the upstream bus number is never passed down
    wire bus_in = (pci_cfg_bus_i != pbus_reg) && (pci_cfg_bus_i >= cbus_reg)
                  && (pci_cfg_bus_i <= sub_reg);
    wire cfwd = pci_cfg_i & pci_cfg_type1_i & bus_in;

    // decode results registered, valid the clock after the request
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mhit_reg <= 1'b0;
        mpref_reg <= 1'b0;
        iohit_reg <= 1'b0;
        cfwd_reg <= 1'b0;
        ct0_reg <= 1'b0;
        cbfwd_reg <= 1'b0;
      end else begin
        mhit_reg <= pci_mem_i & (ph0 | ph1);
        mpref_reg <= pci_mem_i & ((ph0 & pref[0]) | (ph1 & pref[1]));
        iohit_reg <= pci_io_i & pio;
        cfwd_reg <= cfwd;
        ct0_reg <= cfwd & (pci_cfg_bus_i == cbus_reg);
        cbfwd_reg <= (cb_mem_i[s] & ~(ch0 | ch1)) | (cb_io_i[s] & ~cio);
      end
    end

    assign pci_mem_hit_o[s] = mhit_reg;
    assign pci_mem_pref_o[s] = mpref_reg;
    assign pci_io_hit_o[s] = iohit_reg;
    assign cfg_fwd_o[s] = cfwd_reg;
    assign cfg_fwd_type0_o[s] = ct0_reg;
    assign cb_to_pci_o[s] = cbfwd_reg;

    // latency timer runs on the link cycle enable; a low value is software's concern
    cbwd_lat_timer u_lat (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .cclk_en_i(cclk_en),
      .limit_i(lat_reg),
      .frame_start_i(cb_frame_start_i[s]),
      .txn_end_i(cb_txn_end_i[s]),
      .expired_o(lat_expired_o[s]),
      .last_phase_o(cb_last_phase_o[s])
    );
  end
endmodule

// ===== shared/cbwd_pkg.sv
// constants and register map of the cardbus window decode block
package cbwd_pkg;
  localparam int CBWD_ADDR_W = 32;
  localparam int CBWD_BUS_W = 8;
  localparam int CBWD_BE_W = 4;
  localparam int CBWD_OFS_W = 8;
  localparam int CBWD_CMP_W = 20;
  localparam int CBWD_PREF_BITS = 2;
  // config space byte offsets, dword aligned except the bus number and latency byte lanes 19h to 1Bh
  localparam logic [7:0] CBWD_OFS_BUSNUM = 8'h18;
  localparam logic [7:0] CBWD_OFS_PBUS = 8'h18;
  localparam logic [7:0] CBWD_OFS_CBUS = 8'h19;
  localparam logic [7:0] CBWD_OFS_SUB = 8'h1A;
  localparam logic [7:0] CBWD_OFS_LAT = 8'h1B;
  localparam logic [7:0] CBWD_OFS_MEM0_BOT = 8'h1C;
  localparam logic [7:0] CBWD_OFS_MEM0_TOP = 8'h20;
  localparam logic [7:0] CBWD_OFS_MEM1_BOT = 8'h24;
  localparam logic [7:0] CBWD_OFS_MEM1_TOP = 8'h28;
  localparam logic [7:0] CBWD_OFS_IO0_BOT = 8'h2C;
  localparam logic [7:0] CBWD_OFS_IO0_TOP = 8'h30;
  localparam logic [7:0] CBWD_OFS_IO1_BOT = 8'h34;
  localparam logic [7:0] CBWD_OFS_IO1_TOP = 8'h38;
  // field positions
  localparam int CBWD_MEM_LSB = 12;
  localparam int CBWD_IO_LSB = 2;
  localparam int CBWD_IO_MSB = 15;
  localparam int CBWD_IO_PAGE_LSB = 16;
  localparam int CBWD_MEM_FW = CBWD_ADDR_W - CBWD_MEM_LSB;
  localparam int CBWD_IO_FW = CBWD_IO_MSB - CBWD_IO_LSB + 1;
  localparam int CBWD_PAGE_W = CBWD_ADDR_W - CBWD_IO_PAGE_LSB;
  // fixed and reset values
  localparam logic [CBWD_BUS_W-1:0] CBWD_BUS_RST = 8'h00;
  localparam logic [CBWD_BUS_W-1:0] CBWD_LAT_RST = 8'h00;
  localparam logic [CBWD_BUS_W-1:0] CBWD_LAT_MIN_REC = 8'h20;
  localparam logic [CBWD_MEM_FW-1:0] CBWD_MEM_RST = 20'h00000;
  localparam logic [CBWD_IO_FW-1:0] CBWD_IO_RST = 14'h0000;
  localparam logic [CBWD_MEM_LSB-1:0] CBWD_MEM_LOW_ZERO = 12'h000;
  localparam logic [CBWD_IO_LSB-1:0] CBWD_IO_LOW_ZERO = 2'h0;
  localparam logic [CBWD_PAGE_W-1:0] CBWD_IO_PAGE = 16'h0000;
  localparam logic [CBWD_ADDR_W-1:0] CBWD_WORD_ZERO = 32'h00000000;
  typedef logic [CBWD_CMP_W-1:0] cbwd_cmp_t;
  typedef enum logic [1:0] {
    CBWD_LAT_IDLE = 2'b00,
    CBWD_LAT_COUNT = 2'b01,
    CBWD_LAT_EXPIRED = 2'b10
  } cbwd_lat_e;
endpackage
